// [exposure_trig_pkg.sv]
// Constants, register map and types of the exposure trigger block.
// Assumes one 40 MHz system clock shared by every user of the package.
package exposure_trig_pkg;

  // Clock and derived timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int CYC_PER_US_INT = CLK_HZ / 1_000_000;
  localparam int LINE_CLK_NS    = 500;  // Sensor line clock, plain default
  localparam int LINE_CLK_CYC   = (LINE_CLK_NS * CYC_PER_US_INT) / 1000;
  localparam int START_LINES    = 12;
  localparam int START_WAIT_CYC = START_LINES * LINE_CLK_CYC;
  localparam int FILTER_MAX_US  = 255;

  // Widths
  localparam int US_W   = 8;
  localparam int FCYC_W = 14;
  localparam int CNT_W  = 24;

  localparam logic [FCYC_W-1:0] CYC_PER_US = FCYC_W'(CYC_PER_US_INT);
  localparam logic [CNT_W-1:0]  START_WAIT = CNT_W'(START_WAIT_CYC);
  localparam logic [CNT_W-1:0]  CNT_ONE    = 24'h000001;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 24'h000000;

  // Register byte offsets
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_EXP_LEN   = 8'h04;
  localparam logic [7:0] A_FRAME_PER = 8'h08;
  localparam logic [7:0] A_RO_LEN    = 8'h0C;
  localparam logic [7:0] A_LINE_PICK = 8'h10;
  localparam logic [7:0] A_LINE_CFG  = 8'h14;
  localparam logic [7:0] A_SW_TRIG   = 8'h18;
  localparam logic [7:0] A_STATUS    = 8'h1C;

  // Control register fields
  localparam int CTRL_EXT_BIT  = 0;
  localparam int CTRL_ORIG_LSB = 1;
  localparam int CTRL_POL_LSB  = 4;
  localparam int CTRL_PW_BIT   = 6;
  localparam int CTRL_EDGE_BIT = 7;

  // Line configuration fields
  localparam int LCFG_FLIP_BIT = 0;
  localparam int LCFG_THR_BIT  = 1;
  localparam int LCFG_FILT_LSB = 8;
  localparam int LCFG_DLY_LSB  = 16;

  // Status fields
  localparam int ST_EXP_BIT  = 0;
  localparam int ST_RO_BIT   = 1;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_LIVE_LSB = 8;

  // Reset values
  localparam logic [CNT_W-1:0] EXP_LEN_RST   = 24'h000FA0;
  localparam logic [CNT_W-1:0] FRAME_PER_RST = 24'h061A80;
  localparam logic [CNT_W-1:0] RO_LEN_RST    = 24'h009C40;

  typedef enum logic [2:0] {
    ORIG_SOFTWARE, ORIG_LINE1, ORIG_LINE2, ORIG_TIMER, ORIG_COUNTER
  } origin_t;

  typedef enum logic [1:0] {
    OVL_OFF, OVL_READOUT, OVL_AFTER_EXP
  } overlap_t;

  typedef enum logic [1:0] {
    EXP_IDLE, EXP_WAIT, EXP_ON
  } exp_state_t;

endpackage

// [line_cond_if.sv]
// Carrier between the trigger controller and one input line conditioner.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface line_cond_if;
  import exposure_trig_pkg::*;
  logic            raw;
  logic            flip;
  logic [US_W-1:0] filter_us;
  logic [US_W-1:0] delay_us;
  logic            level;

  modport ctl (output raw, output flip, output filter_us, output delay_us,
               input level);
  modport lcd (input raw, input flip, input filter_us, input delay_us,
               output level);
endinterface

// [line_conditioner.sv]
// One input line: glitch filter, programmable start delay, inversion.
// Assumes the raw line is already synchronous to sys_clk_i.
`timescale 1ns/1ps
module line_conditioner
  import exposure_trig_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  line_cond_if.lcd lc
);

  logic [FCYC_W-1:0] filt_cyc;
  logic [FCYC_W-1:0] dly_cyc;
  logic [FCYC_W-1:0] stable_cnt_ff;
  logic [FCYC_W-1:0] dly_cnt_ff;
  logic              filt_ff;
  logic              dly_ff;
  logic              level_ff;

  // Microsecond settings as cycle counts; 255 us fits in 14 bits
  assign filt_cyc = FCYC_W'(lc.filter_us * CYC_PER_US);
  assign dly_cyc  = FCYC_W'(lc.delay_us * CYC_PER_US);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      stable_cnt_ff <= '0;
      filt_ff       <= 1'b0;
    end
    else if (lc.raw == filt_ff)
      stable_cnt_ff <= '0;
    else if (stable_cnt_ff >= filt_cyc)
    begin
      filt_ff       <= lc.raw;
      stable_cnt_ff <= '0;
    end
    else
      stable_cnt_ff <= stable_cnt_ff + 1'b1;
  end

  // delay then inversion
  // Only one pending edge is timed; pulses shorter than the delay are lost
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      dly_cnt_ff <= '0;
      dly_ff     <= 1'b0;
      level_ff   <= 1'b0;
    end
    else
    begin
      if (filt_ff == dly_ff)
        dly_cnt_ff <= '0;
      else if (dly_cnt_ff >= dly_cyc)
      begin
        dly_ff     <= filt_ff;
        dly_cnt_ff <= '0;
      end
      else
        dly_cnt_ff <= dly_cnt_ff + 1'b1;
      level_ff <= dly_ff ^ lc.flip;
    end
  end

  assign lc.level = level_ff;

  property p_filter_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(filt_ff) |-> $past(stable_cnt_ff) >= $past(filt_cyc);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter output changed before hold time");

  property p_delay_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(dly_ff) |-> $past(dly_cnt_ff) >= $past(dly_cyc);
  endproperty
  a_delay_hold: assert property (p_delay_hold)
    else $error("delayed line changed early");

endmodule

// [exposure_trigger_overlap_control.sv]
// Exposure start control: trigger source choice and overlap policy.
// Assumes an APB master on the system clock and synchronous line inputs.
`timescale 1ns/1ps

// Summary of operation
// - Software command write starts an exposure
// - Lines filtered, delayed, optionally inverted first
// - Timer one done event can trigger
// - Counter one done event can trigger
// - Two lines with per-line settings and status
// - Glitch filter programmable 0 to 255 us
// - Off policy drops triggers during frame
// - Readout policy accepts once readout begins
// - After-exposure policy accepts when exposure ends
// - Early trigger latched, next exposure postponed
// - Exposure starts 12 line clocks after accept
// - Next exposure may overlap previous readout
// - Short exposure delayed to end with readout
// - Second readout follows first without gap
// - Pulse exposure stretched until readout ends
// - Free run uses internal frame timer
// - External sync uses only selected source
module exposure_trigger_overlap_control
  import exposure_trig_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [1:0]  line_raw_i,
  input  wire logic        timer_one_done_i,
  input  wire logic        counter_one_done_i,
  output logic      [1:0]  input_threshold_sel_o,
  output logic             exposure_o,
  output logic             readout_o,
  output logic             trigger_accept_o
);

  logic              external_sync_select_ff;
  origin_t           exposure_start_origin_ff;
  overlap_t          overlap_policy_ff;
  logic              pulse_width_exposure_ff;
  logic              edge_sense_ff;
  logic [CNT_W-1:0]  exp_len_ff;
  logic [CNT_W-1:0]  frame_per_ff;
  logic [CNT_W-1:0]  ro_len_ff;
  logic              line_pick_ff;
  logic [1:0]        flip_ff;
  logic [1:0]        thr_ff;
  logic [US_W-1:0]   filt_us_ff [2];
  logic [US_W-1:0]   dly_us_ff [2];
  logic              sw_pulse_ff;
  logic [31:0]       prdata_ff;
  logic [1:0]        line_live_state;
  logic [1:0]        act_prev_ff;
  logic [1:0]        line_act;
  logic [1:0]        line_edge;
  logic [CNT_W-1:0]  fr_cnt_ff;
  logic              fr_tick;
  logic              trig_evt;
  logic              trig_lvl;
  logic              idle;
  logic              can_take;
  logic              launch;
  logic              pending_ff;
  exp_state_t        exp_state_ff;
  logic [CNT_W-1:0]  wait_cnt_ff;
  logic [CNT_W-1:0]  exp_cnt_ff;
  logic [CNT_W-1:0]  ro_cnt_ff;
  logic [CNT_W-1:0]  wait_sel;
  logic [CNT_W-1:0]  exp_load;
  logic [CNT_W-1:0]  ro_load;
  logic              pw_active;
  logic              exp_done;
  logic              exp_end;
  logic              wr_en;
  logic              addr_ok;
  logic [31:0]       rd_mux;

  // APB decode; zero wait states, unmapped or unaligned gives an error
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign addr_ok   = (paddr_i[1:0] == 2'b00) && (paddr_i <= A_STATUS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o  = prdata_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      external_sync_select_ff  <= 1'b0;
      exposure_start_origin_ff <= ORIG_SOFTWARE;
      overlap_policy_ff        <= OVL_OFF;
      pulse_width_exposure_ff  <= 1'b0;
      edge_sense_ff            <= 1'b0;
      exp_len_ff               <= EXP_LEN_RST;
      frame_per_ff             <= FRAME_PER_RST;
      ro_len_ff                <= RO_LEN_RST;
      line_pick_ff             <= 1'b0;
      flip_ff                  <= 2'b00;
      thr_ff                   <= 2'b00;
      filt_us_ff               <= '{default: '0};
      dly_us_ff                <= '{default: '0};
    end
    else if (wr_en)
    begin
      unique case (paddr_i)
        A_CTRL:
        begin
          external_sync_select_ff  <= pwdata_i[CTRL_EXT_BIT];
          exposure_start_origin_ff <=
            origin_t'(pwdata_i[CTRL_ORIG_LSB +: 3]);
          overlap_policy_ff <= overlap_t'(pwdata_i[CTRL_POL_LSB +: 2]);
          pulse_width_exposure_ff  <= pwdata_i[CTRL_PW_BIT];
          edge_sense_ff            <= pwdata_i[CTRL_EDGE_BIT];
        end
        A_EXP_LEN:   exp_len_ff   <= pwdata_i[CNT_W-1:0];
        A_FRAME_PER: frame_per_ff <= pwdata_i[CNT_W-1:0];
        A_RO_LEN:    ro_len_ff    <= pwdata_i[CNT_W-1:0];
        A_LINE_PICK: line_pick_ff <= pwdata_i[0];
        A_LINE_CFG:
        begin
          flip_ff[line_pick_ff]    <= pwdata_i[LCFG_FLIP_BIT];
          thr_ff[line_pick_ff]     <= pwdata_i[LCFG_THR_BIT];
          filt_us_ff[line_pick_ff] <= pwdata_i[LCFG_FILT_LSB +: US_W];
          dly_us_ff[line_pick_ff]  <= pwdata_i[LCFG_DLY_LSB +: US_W];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      sw_pulse_ff <= 1'b0;
    else
      sw_pulse_ff <= wr_en && (paddr_i == A_SW_TRIG) && pwdata_i[0];
  end

  // Read mux; the setup phase loads it so data stands in the access phase
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr_i)
      A_CTRL:
      begin
        rd_mux[CTRL_EXT_BIT]       = external_sync_select_ff;
        rd_mux[CTRL_ORIG_LSB +: 3] = exposure_start_origin_ff;
        rd_mux[CTRL_POL_LSB +: 2]  = overlap_policy_ff;
        rd_mux[CTRL_PW_BIT]        = pulse_width_exposure_ff;
        rd_mux[CTRL_EDGE_BIT]      = edge_sense_ff;
      end
      A_EXP_LEN:   rd_mux[CNT_W-1:0] = exp_len_ff;
      A_FRAME_PER: rd_mux[CNT_W-1:0] = frame_per_ff;
      A_RO_LEN:    rd_mux[CNT_W-1:0] = ro_len_ff;
      A_LINE_PICK: rd_mux[0] = line_pick_ff;
      A_LINE_CFG:
      begin
        rd_mux[LCFG_FLIP_BIT]         = flip_ff[line_pick_ff];
        rd_mux[LCFG_THR_BIT]          = thr_ff[line_pick_ff];
        rd_mux[LCFG_FILT_LSB +: US_W] = filt_us_ff[line_pick_ff];
        rd_mux[LCFG_DLY_LSB +: US_W]  = dly_us_ff[line_pick_ff];
      end
      A_STATUS:
      begin
        rd_mux[ST_EXP_BIT]       = exposure_o;
        rd_mux[ST_RO_BIT]        = readout_o;
        rd_mux[ST_PEND_BIT]      = pending_ff;
        rd_mux[ST_LIVE_LSB +: 2] = line_live_state;
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      prdata_ff <= 32'h00000000;
    else if (psel_i && !penable_i)
      prdata_ff <= rd_mux;
  end

  for (genvar g = 0; g < 2; g++)
  begin : gen_line
    line_cond_if lc ();
    assign lc.raw       = line_raw_i[g];
    assign lc.flip      = flip_ff[g];
    assign lc.filter_us = filt_us_ff[g];
    assign lc.delay_us  = dly_us_ff[g];
    assign line_live_state[g] = lc.level;
    line_conditioner u_cond (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .lc        (lc)
    );
  end

  assign input_threshold_sel_o = thr_ff;

  // edge sense set 0 selects rising edges
  assign line_act  = line_live_state ^ {2{edge_sense_ff}};
  assign line_edge = line_act & ~act_prev_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      act_prev_ff <= 2'b00;
    else
      act_prev_ff <= line_act;
  end

  assign fr_tick = !external_sync_select_ff && (fr_cnt_ff == CNT_ZERO);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || external_sync_select_ff)
      fr_cnt_ff <= CNT_ZERO;
    else if (fr_cnt_ff == CNT_ZERO)
      fr_cnt_ff <= frame_per_ff - CNT_ONE;
    else
      fr_cnt_ff <= fr_cnt_ff - CNT_ONE;
  end

  // only the selected origin counts; codes 5 to 7 select nothing
  always_comb
  begin
    trig_evt = 1'b0;
    trig_lvl = 1'b0;
    if (!external_sync_select_ff)
      trig_evt = fr_tick;
    else
    begin
      case (exposure_start_origin_ff)
        ORIG_SOFTWARE: trig_evt = sw_pulse_ff;
        ORIG_LINE1:
        begin
          trig_evt = line_edge[0];
          trig_lvl = line_act[0];
        end
        ORIG_LINE2:
        begin
          trig_evt = line_edge[1];
          trig_lvl = line_act[1];
        end
        ORIG_TIMER:    trig_evt = timer_one_done_i;
        ORIG_COUNTER:  trig_evt = counter_one_done_i;
        default:       trig_evt = 1'b0;
      endcase
    end
  end

  // off policy waits for whole frame
  assign idle = (exp_state_ff == EXP_IDLE);
  always_comb
  begin
    case (overlap_policy_ff)
      OVL_READOUT:   can_take = idle;
      OVL_AFTER_EXP: can_take = idle;
      default:       can_take = idle && (ro_cnt_ff == CNT_ZERO) &&
                                !pending_ff;
    endcase
  end
  assign launch = can_take && (trig_evt || pending_ff);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      pending_ff <= 1'b0;
    else if (overlap_policy_ff == OVL_AFTER_EXP && trig_evt && !idle)
      pending_ff <= 1'b1;
    // A latch left from the after-exposure policy is dropped on a policy
    // change, so the off policy cannot stall on a stale request
    else if (launch || overlap_policy_ff != OVL_AFTER_EXP)
      pending_ff <= 1'b0;
  end

  // delay so exposure ends with readout
  assign pw_active = external_sync_select_ff && pulse_width_exposure_ff;
  assign exp_load  = (exp_len_ff == CNT_ZERO) ? CNT_ONE : exp_len_ff;
  assign ro_load   = (ro_len_ff == CNT_ZERO) ? CNT_ONE : ro_len_ff;
  assign wait_sel  = (!pw_active &&
                      {1'b0, ro_cnt_ff} > ({1'b0, exp_load} +
                                            {1'b0, START_WAIT})) ?
                     (ro_cnt_ff - exp_load - CNT_ONE) : START_WAIT;
  // Minus one: exposure must end on the very edge that empties readout

  // pulse exposure held until readout ends
  assign exp_done = pw_active ? !trig_lvl : (exp_cnt_ff <= CNT_ONE);
  assign exp_end  = (exp_state_ff == EXP_ON) && exp_done &&
                    (ro_cnt_ff <= CNT_ONE);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      exp_state_ff <= EXP_IDLE;
      wait_cnt_ff  <= CNT_ZERO;
      exp_cnt_ff   <= CNT_ZERO;
    end
    else
    begin
      unique case (exp_state_ff)
        EXP_IDLE:
          if (launch)
          begin
            exp_state_ff <= EXP_WAIT;
            wait_cnt_ff  <= wait_sel;
          end
        EXP_WAIT:
          if (wait_cnt_ff <= CNT_ONE)
          begin
            exp_state_ff <= EXP_ON;
            exp_cnt_ff   <= exp_load;
          end
          else
            wait_cnt_ff <= wait_cnt_ff - CNT_ONE;
        EXP_ON:
          if (exp_end)
            exp_state_ff <= EXP_IDLE;
          else if (exp_cnt_ff > CNT_ONE)
            exp_cnt_ff <= exp_cnt_ff - CNT_ONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      ro_cnt_ff <= CNT_ZERO;
    else if (exp_end)
      ro_cnt_ff <= ro_load;
    else if (ro_cnt_ff != CNT_ZERO)
      ro_cnt_ff <= ro_cnt_ff - CNT_ONE;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      trigger_accept_o <= 1'b0;
    else
      trigger_accept_o <= launch;
  end

  assign exposure_o = (exp_state_ff == EXP_ON);
  assign readout_o  = (ro_cnt_ff != CNT_ZERO);

  // Checks on the trigger path
  localparam int WAIT_CHK = START_WAIT_CYC;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_sw_trig;
    external_sync_select_ff && exposure_start_origin_ff == ORIG_SOFTWARE
    && sw_pulse_ff && can_take |=> trigger_accept_o;
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("software trigger not accepted");

  property p_timer;
    external_sync_select_ff && exposure_start_origin_ff == ORIG_TIMER
    && timer_one_done_i && can_take |=> trigger_accept_o;
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer event not accepted");

  property p_counter;
    external_sync_select_ff && exposure_start_origin_ff == ORIG_COUNTER
    && counter_one_done_i && can_take |=> trigger_accept_o;
  endproperty
  a_counter: assert property (p_counter)
    else $error("counter event not accepted");

  property p_off;
    overlap_policy_ff == OVL_OFF && (exposure_o || readout_o)
    |=> !trigger_accept_o;
  endproperty
  a_off: assert property (p_off)
    else $error("trigger taken inside frame with policy off");

  property p_readout;
    overlap_policy_ff == OVL_READOUT && idle && readout_o && trig_evt
    |=> trigger_accept_o ##1 !idle;
  endproperty
  a_readout: assert property (p_readout)
    else $error("trigger during readout not accepted");

  property p_latch;
    overlap_policy_ff == OVL_AFTER_EXP && exposure_o && trig_evt
    |=> pending_ff;
  endproperty
  a_latch: assert property (p_latch)
    else $error("early trigger not latched");

  property p_start;
    launch && ro_cnt_ff == CNT_ZERO |-> ##WAIT_CHK !exposure_o ##1 exposure_o;
  endproperty
  a_start: assert property (p_start)
    else $error("exposure start not 12 line clocks after accept");

  property p_align;
    $fell(exposure_o) |-> $past(ro_cnt_ff) <= CNT_ONE;
  endproperty
  a_align: assert property (p_align)
    else $error("exposure ended before previous readout");

  property p_no_gap;
    $fell(exposure_o) |-> readout_o && ro_cnt_ff == ro_load;
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("readout did not follow exposure at once");

  property p_stretch;
    exposure_o && ro_cnt_ff > CNT_ONE |=> exposure_o;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("exposure ended while readout busy");

  property p_ext;
    external_sync_select_ff && exposure_start_origin_ff == ORIG_TIMER &&
    launch |-> timer_one_done_i || pending_ff;
  endproperty
  a_ext: assert property (p_ext)
    else $error("accept from an unselected source");

  c_overlap: cover property (exposure_o && readout_o);
  c_pending: cover property (launch && pending_ff);
  c_line:    cover property (launch && line_edge[0]);

endmodule

// [trig_line_src.sv]
// Model of the external source that drives the two trigger input lines.
// Assumes the bench asks for pulses through the task below.
`timescale 1ns/1ps
module trig_line_src
(
  input  wire logic       sys_clk_i,
  output logic      [1:0] line_raw_o
);
  // Lines idle low, like an unpowered isolator input
  initial line_raw_o = 2'h0;

  // rising active edge
  // Drive one line high for len cycles, then back low
  task automatic pulse(input int ln, input int len);
    @(posedge sys_clk_i);
    line_raw_o[ln] <= 1'b1;
    repeat (len) @(posedge sys_clk_i);
    line_raw_o[ln] <= 1'b0;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the exposure trigger block, driven over APB.
// Assumes zero wait APB answers and the package default line clock.
`timescale 1ns/1ps
module tb_top;
  import exposure_trig_pkg::*;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic        tmr, cnt, expo, rdo, acc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  lraw, thr;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          acc_cnt = 0;
  int          n, a0;

  exposure_trigger_overlap_control exposure_trigger_overlap_control_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .line_raw_i(lraw), .timer_one_done_i(tmr),
    .counter_one_done_i(cnt), .input_threshold_sel_o(thr),
    .exposure_o(expo), .readout_o(rdo), .trigger_accept_o(acc));
  trig_line_src trig_line_src_inst (.sys_clk_i(sys_clk_i),
                                    .line_raw_o(lraw));

  // Clock at 40 MHz
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Count accepted triggers for drop and accept count checks
  always @(posedge sys_clk_i)
    if (acc === 1'b1)
      acc_cnt <= acc_cnt + 1;

  task automatic wrap_up;
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int k);
    return (k == 0) ? acc : (k == 1) ? expo : rdo;
  endfunction

  // Cycles until output k reaches lv, sampled 1 ns after each edge
  task automatic wt(input int k, input logic lv);
    n = 0;
    // Look 1 ns on first, so a pulse launched on this edge is seen
    #1;
    while (sig(k) !== lv && n < 60000)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (sig(k) !== lv)
      chk("wait limit", 32'(lv), 32'(sig(k)));
  endtask

  // Event 0 software write, 1 timer one done, 2 counter one done
  task automatic fire(input int k);
    if (k == 0)
      apb(1'b1, A_SW_TRIG, 32'h00000001);
    else
    begin
      @(posedge sys_clk_i);
      {cnt, tmr} <= (k == 1) ? 2'h1 : 2'h2;
      @(posedge sys_clk_i);
      {cnt, tmr} <= 2'h0;
    end
  endtask

  function automatic logic [31:0] ctl(input int o, input int p);
    return 32'h00000001 | 32'(o << CTRL_ORIG_LSB) | 32'(p << CTRL_POL_LSB);
  endfunction

  // Hang guard, well above the longest expected run
  initial
  begin
    #(25ns * 80000);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    {rst_n_i, psel, penable, pwrite, tmr, cnt} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset outputs", 32'h0, 32'({acc, expo, rdo}));
    wt(0, 1'b1);
    chk("free run start", 32'h1, 32'(n <= 3));
    apb(1'b0, A_EXP_LEN, 32'h0);
    chk("exp len reset", 32'(EXP_LEN_RST), rd);
    apb(1'b0, A_RO_LEN, 32'h0);
    chk("ro len reset", 32'(RO_LEN_RST), rd);
    wt(2, 1'b1);
    wt(2, 1'b0);
    apb(1'b1, A_CTRL, ctl(0, 0));
    apb(1'b1, A_EXP_LEN, 32'h00000008);
    apb(1'b1, A_RO_LEN, 32'h0000012C);
    fire(0);
    wt(0, 1'b1);
    chk("sw accept delay", 32'h1, 32'(n));
    wt(1, 1'b1);
    chk("start wait", 32'(START_WAIT_CYC), 32'(n));
    wt(1, 1'b0);
    chk("exposure length", 32'h8, 32'(n));
    a0 = acc_cnt;
    fire(0);
    wt(2, 1'b0);
    repeat (5) @(posedge sys_clk_i);
    chk("off drop", 32'(a0), 32'(acc_cnt));
    for (int k = 1; k < 3; k++)
    begin
      apb(1'b1, A_CTRL, ctl(k + 2, 0));
      a0 = acc_cnt;
      fire(3 - k);
      repeat (20) @(posedge sys_clk_i);
      chk("other source", 32'(a0), 32'(acc_cnt));
      fire(k);
      wt(0, 1'b1);
      wt(1, 1'b1);
      wt(1, 1'b0);
      wt(2, 1'b0);
      chk("internal event frame", 32'h12C, 32'(n));
    end
    apb(1'b1, A_LINE_PICK, 32'h0);
    apb(1'b1, A_LINE_CFG, 32'h00000102);
    apb(1'b0, A_LINE_CFG, 32'h0);
    chk("line cfg", 32'h00000102, rd);
    chk("threshold", 32'h1, 32'(thr));
    apb(1'b1, A_CTRL, ctl(1, 0));
    a0 = acc_cnt;
    trig_line_src_inst.pulse(0, 30);
    repeat (60) @(posedge sys_clk_i);
    chk("short glitch", 32'(a0), 32'(acc_cnt));
    trig_line_src_inst.pulse(0, 100);
    repeat (10) @(posedge sys_clk_i);
    chk("line trigger", 32'(a0 + 1), 32'(acc_cnt));
    wt(2, 1'b1);
    wt(2, 1'b0);
    apb(1'b1, A_LINE_PICK, 32'h1);
    apb(1'b1, A_LINE_CFG, 32'h00000003);
    repeat (10) @(posedge sys_clk_i);
    apb(1'b0, A_STATUS, 32'h0);
    chk("live inverted", 32'h1, 32'(rd[ST_LIVE_LSB + 1]));
    chk("threshold two", 32'h3, 32'(thr));
    apb(1'b1, A_CTRL, ctl(0, 1));
    a0 = acc_cnt;
    fire(0);
    wt(1, 1'b1);
    wt(1, 1'b0);
    fire(0);
    wt(1, 1'b1);
    chk("readout accept", 32'(a0 + 2), 32'(acc_cnt));
    chk("overlap run", 32'h1, 32'(rdo));
    // Exposure of 8 ends as readout ends, then a fresh 300 readout
    wt(2, 1'b0);
    chk("no gap", 32'h00000134, 32'(n));
    apb(1'b1, A_CTRL, ctl(0, 2));
    a0 = acc_cnt;
    fire(0);
    fire(0);
    apb(1'b0, A_STATUS, 32'h0);
    chk("pending", 32'h1, 32'(rd[ST_PEND_BIT]));
    wt(1, 1'b1);
    wt(1, 1'b0);
    wt(0, 1'b1);
    chk("after exp accept", 32'h1, 32'(n <= 3));
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk("postponed end", 32'h1, 32'(rdo));
    wt(2, 1'b0);
    // Pulse-width exposure on line one; a short pulse during readout
    // must keep exposing until that readout ends
    apb(1'b1, A_CTRL, ctl(1, 1) | 32'h00000040);
    trig_line_src_inst.pulse(0, 400);
    wt(1, 1'b1);
    wt(1, 1'b0);
    trig_line_src_inst.pulse(0, 100);
    wt(1, 1'b1);
    wt(1, 1'b0);
    wt(2, 1'b0);
    chk("pulse stretch", 32'h0000012C, 32'(n));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    wrap_up();
  end
endmodule
